/* File: data_memory_space_decode_tb_top.sv */
// testbench for the data memory space decoder
`timescale 1ns/100ps
module data_memory_space_decode_tb_top;
  logic clk_i = 0, nrst_i = 0, iram_req_i = 0, iram_wr_i = 0, iram_indirect_i = 0;
  logic [7:0] iram_addr_i = 0, iram_wdata_i = 0, opcode_i = 0, acc_i = 0, xmove_wdata_i = 0;
  logic opcode_valid_i = 0, stack_push_i = 0, stack_pop_i = 0, code_move_i = 0;
  logic xmove_req_i = 0, xmove_wr_i = 0, xmove_use_ptr_i = 0;
  logic [15:0] pc_i = 0, xmove_addr_i = 0;
  logic [2:0] stretch_i = 0;
  logic [7:0] sfr_rdata_o, stack_pointer_o, xmove_rdata_o, ext_addr_hi_o, ext_ad_o, mem_ad;
  logic sfr_sel_o, scratch_sel_o, bit_ok_o, xmove_done_o, xmove_busy_o;
  logic ext_ale_o, ext_rd_n_o, ext_wr_n_o, ext_ad_oe_n_o;
  logic [15:0] code_addr_o, active_data_pointer_o;
  wire [7:0] ext_ad_i = !ext_ad_oe_n_o ? ext_ad_o : mem_ad;
  int mismatches = 0, samples_checked = 0, cyc = 0, i;
  dmd_data_memory dmd_data_memory_inst (.*);
  dmd_ext_mem dmd_ext_mem_inst (.clk_i(clk_i), .ale_i(ext_ale_o), .rd_n_i(ext_rd_n_o),
    .wr_n_i(ext_wr_n_o), .addr_hi_i(ext_addr_hi_o), .ad_i(ext_ad_i),
    .ad_oe_n_i(ext_ad_oe_n_o), .ad_o(mem_ad));
  always #20 clk_i = ~clk_i;
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      close_out;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tk;
    @(posedge clk_i);
    #1;
  endtask
  task automatic acc(input logic w, input logic ind, input logic [7:0] a, input logic [7:0] d);
    iram_req_i = 1;
    iram_wr_i = w;
    iram_indirect_i = ind;
    iram_addr_i = a;
    iram_wdata_i = d;
    tk;
    iram_req_i = 0;
    iram_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(0, 0, a, 8'h00);
    chk(sfr_rdata_o, e);
  endtask
  task automatic op(input logic [7:0] c);
    opcode_valid_i = 1;
    opcode_i = c;
    tk;
    opcode_valid_i = 0;
  endtask
  // d is write data, or the expected read data; n is the expected length in clocks
  task automatic mv(input logic w, input logic [15:0] a, input logic [7:0] d,
    input logic [2:0] s, input int n);
    int k;
    xmove_req_i = 1;
    xmove_wr_i = w;
    xmove_addr_i = a;
    xmove_wdata_i = d;
    stretch_i = s;
    tk;
    xmove_req_i = 0;
    chk(xmove_busy_o, 1'b1);
    k = 0;
    while (xmove_done_o !== 1'b1 && k < 60) begin
      tk;
      k++;
    end
    chk(k[15:0], n[15:0]);
    if (!w) chk(xmove_rdata_o, d);
    tk;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    nrst_i = 1;
    rd(8'h81, 8'h07);
    chk(sfr_sel_o, 1'b1);
    chk(bit_ok_o, 1'b0);
    for (i = 2; i < 6; i++) rd(8'h80 + i[7:0], 8'h00);
    rd(8'h86, 8'h00);
    rd(8'hC4, 8'hFE);
    rd(8'hA0, 8'hFF);
    chk(bit_ok_o, 1'b1);
    acc(1, 1, 8'h82, 8'hEE);
    chk(scratch_sel_o, 1'b1);
    chk(sfr_sel_o, 1'b0);
    rd(8'h82, 8'h00);
    for (i = 1; i < 6; i++) acc(1, 0, 8'h80 + i[7:0], 8'h11 * i[7:0]);
    for (i = 1; i < 6; i++) rd(8'h80 + i[7:0], 8'h11 * i[7:0]);
    acc(1, 0, 8'hA0, 8'h00);
    rd(8'hA0, 8'hFF);
    stack_push_i = 1;
    tk;
    chk(stack_pointer_o, 8'h12);
    stack_pop_i = 1;
    tk;
    chk(stack_pointer_o, 8'h12);
    stack_push_i = 0;
    tk;
    stack_pop_i = 0;
    chk(stack_pointer_o, 8'h11);
    op(8'hA5);
    chk(active_data_pointer_o, 16'h3321);
    op(8'hA3);
    chk(active_data_pointer_o, 16'h3321);
    acc(1, 0, 8'h86, 8'h01);
    chk(active_data_pointer_o, 16'h5544);
    rd(8'h86, 8'h01);
    op(8'hA5);
    chk(active_data_pointer_o, 16'h5543);
    rd(8'h82, 8'h21);
    acc(1, 0, 8'h84, 8'h00);
    acc(1, 0, 8'h85, 8'h00);
    op(8'hA5);
    chk(active_data_pointer_o, 16'hFFFF);
    acc_i = 8'h10;
    code_move_i = 1;
    tk;
    chk(code_addr_o, 16'h000F);
    code_move_i = 0;
    pc_i = 16'h1234;
    tk;
    chk(code_addr_o, 16'h1234);
    mv(1, 16'h0100, 8'hA5, 3'h0, 8);
    mv(0, 16'h0100, 8'hA5, 3'h1, 12);
    acc(1, 0, 8'hC4, 8'h01);
    rd(8'hC4, 8'hFF);
    mv(1, 16'h0100, 8'h3C, 3'h7, 8);
    mv(0, 16'h0100, 8'h3C, 3'h7, 8);
    mv(1, 16'h03FF, 8'h96, 3'h7, 8);
    mv(0, 16'h03FF, 8'h96, 3'h7, 8);
    mv(1, 16'h0400, 8'h77, 3'h2, 16);
    mv(0, 16'h0400, 8'h77, 3'h2, 16);
    xmove_use_ptr_i = 1;
    mv(1, 16'h0000, 8'h5A, 3'h0, 8);
    xmove_use_ptr_i = 0;
    mv(0, 16'hFFFF, 8'h5A, 3'h3, 20);
    acc(1, 0, 8'hC4, 8'h00);
    mv(0, 16'h0100, 8'hA5, 3'h3, 20);
    close_out;
  end
endmodule

/* File: dmd_data_memory.sv */
// data memory space decoder: pointers, stack pointer, on-chip and external moves
`timescale 1ns/100ps
module dmd_data_memory (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // internal data and register access from the core
  input wire logic iram_req_i,
  input wire logic iram_wr_i,
  input wire logic iram_indirect_i,
  input wire logic [7:0] iram_addr_i,
  input wire logic [7:0] iram_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_sel_o,
  output logic scratch_sel_o,
  output logic bit_ok_o,
  // instruction stream and stack
  input wire logic opcode_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic stack_push_i,
  input wire logic stack_pop_i,
  output logic [7:0] stack_pointer_o,
  // program space addressing
  input wire logic [15:0] pc_i,
  input wire logic [7:0] acc_i,
  input wire logic code_move_i,
  output logic [15:0] code_addr_o,
  // external data move request
  input wire logic xmove_req_i,
  input wire logic xmove_wr_i,
  input wire logic xmove_use_ptr_i,
  input wire logic [15:0] xmove_addr_i,
  input wire logic [7:0] xmove_wdata_i,
  input wire logic [2:0] stretch_i,
  output logic [7:0] xmove_rdata_o,
  output logic xmove_done_o,
  output logic xmove_busy_o,
  output logic [15:0] active_data_pointer_o,
  // external multiplexed bus
  output logic ext_ale_o,
  output logic ext_rd_n_o,
  output logic ext_wr_n_o,
  output logic [7:0] ext_addr_hi_o,
  output logic [7:0] ext_ad_o,
  output logic ext_ad_oe_n_o,
  input wire logic [7:0] ext_ad_i
);
  import dmd_pkg::*;

  typedef struct packed {
    logic [7:0] stack_pointer;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic pointer_select;
    logic onchip_xram_enable;
    logic [7:0] rdata;
    logic sfr_sel;
    logic scratch_sel;
    logic bit_ok;
    logic [15:0] code_addr;
    dmd_state_t state;
    logic [5:0] cnt;
    logic xwr;
    logic [7:0] xdata;
    logic xdone;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr_hi;
    logic [7:0] ad_out;
    logic ad_oe_n;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic busy;
    logic [15:0] aptr;
    logic [7:0] xwdata;
  } dmd_st_t;

  dmd_st_t q;
  dmd_st_t d;

  logic dec_sfr_sel;
  logic dec_scratch_sel;
  logic dec_bit_ok;
  logic dec_xram_hit;
  logic [15:0] active_ptr;
  logic [15:0] move_addr;
  logic xram_en;
  logic xram_we;
  logic [7:0] xram_rdata;

  // the move address comes from the active pointer or the core's own
  assign active_ptr = q.pointer_select ? q.dp1 : q.dp0;
  assign move_addr = xmove_use_ptr_i ? active_ptr : xmove_addr_i;

  dmd_space_decode u_decode (
    .iram_addr_i(iram_addr_i),
    .iram_indirect_i(iram_indirect_i),
    .xmove_addr_i(move_addr),
    .onchip_en_i(q.onchip_xram_enable),
    .sfr_sel_o(dec_sfr_sel),
    .scratch_sel_o(dec_scratch_sel),
    .bit_ok_o(dec_bit_ok),
    .xram_hit_o(dec_xram_hit)
  );

  // the SRAM is touched only in the request cycle of an on-chip hit
  assign xram_en = (q.state == DMD_IDLE) && xmove_req_i && dec_xram_hit;
  assign xram_we = xmove_wr_i;

  dmd_xram u_xram (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(xram_en),
    .we_i(xram_we),
    .addr_i(move_addr[XRAM_ADDR_W-1:0]),
    .wdata_i(xmove_wdata_i),
    .rdata_o(xram_rdata)
  );

  always_comb begin
    d = q;
    d.xdone = 1'b0;
    // bus pins pass two flops before anything looks at them
    d.sync1 = ext_ad_i;
    d.sync2 = q.sync1;

    d.sfr_sel = iram_req_i && dec_sfr_sel;
    d.scratch_sel = iram_req_i && dec_scratch_sel;
    d.bit_ok = iram_req_i && dec_bit_ok;

    // register read; anything not held here reads all ones
    d.rdata = UNIMPL_READ;
    if (iram_req_i && dec_sfr_sel) begin
      if (iram_addr_i == SFR_STACK_POINTER) begin
        d.rdata = q.stack_pointer;
      end else if (iram_addr_i == SFR_DATA_POINTER0_LOW) begin
        d.rdata = q.dp0[7:0];
      end else if (iram_addr_i == SFR_DATA_POINTER0_HIGH) begin
        d.rdata = q.dp0[15:8];
      end else if (iram_addr_i == SFR_DATA_POINTER1_LOW) begin
        d.rdata = q.dp1[7:0];
      end else if (iram_addr_i == SFR_DATA_POINTER1_HIGH) begin
        d.rdata = q.dp1[15:8];
      end else if (iram_addr_i == SFR_POINTER_SELECT) begin
        d.rdata = {POINTER_SELECT_RSVD, q.pointer_select};
      end else if (iram_addr_i == SFR_MEMORY_MODE_CONTROL) begin
        d.rdata = {MEMORY_MODE_UNIMPL, q.onchip_xram_enable};
      end
    end

    // stack moves first so that a register write in the same cycle wins
    if (stack_push_i && !stack_pop_i) begin
      d.stack_pointer = q.stack_pointer + 8'h01;
    end else if (stack_pop_i && !stack_push_i) begin
      d.stack_pointer = q.stack_pointer - 8'h01;
    end

    if (opcode_valid_i && (opcode_i == OPC_POINTER_DECREMENT)) begin
      if (q.pointer_select) begin
        d.dp1 = q.dp1 - 16'h0001;
      end else begin
        d.dp0 = q.dp0 - 16'h0001;
      end
    end

    // direct writes only; an indirect access never reaches these
    if (iram_req_i && iram_wr_i && dec_sfr_sel) begin
      if (iram_addr_i == SFR_STACK_POINTER) begin
        d.stack_pointer = iram_wdata_i;
      end else if (iram_addr_i == SFR_DATA_POINTER0_LOW) begin
        d.dp0[7:0] = iram_wdata_i;
      end else if (iram_addr_i == SFR_DATA_POINTER0_HIGH) begin
        d.dp0[15:8] = iram_wdata_i;
      end else if (iram_addr_i == SFR_DATA_POINTER1_LOW) begin
        d.dp1[7:0] = iram_wdata_i;
      end else if (iram_addr_i == SFR_DATA_POINTER1_HIGH) begin
        d.dp1[15:8] = iram_wdata_i;
      end else if (iram_addr_i == SFR_POINTER_SELECT) begin
        d.pointer_select = iram_wdata_i[POINTER_SELECT_BIT];
      end else if (iram_addr_i == SFR_MEMORY_MODE_CONTROL) begin
        d.onchip_xram_enable = iram_wdata_i[ONCHIP_XRAM_ENABLE_BIT];
      end
    end

    // program space: fetch address or base plus accumulator for code moves
    if (code_move_i) begin
      d.code_addr = active_ptr + {8'h00, acc_i};
    end else begin
      d.code_addr = pc_i;
    end

    case (q.state)
      DMD_IDLE: begin
        if (xmove_req_i) begin
          d.xwr = xmove_wr_i;
          // write data captured at the request so the core need not hold it
          d.xwdata = xmove_wdata_i;
          if (dec_xram_hit) begin
            // fixed length whatever the stretch setting
            d.cnt = 6'(ONCHIP_MOVE_CLKS - 1);
            d.state = DMD_ONCHIP;
          end else begin
            // full 16-bit address on the two ports, low byte latched on ale
            d.ale = 1'b1;
            d.ad_out = move_addr[7:0];
            d.addr_hi = move_addr[15:8];
            d.ad_oe_n = 1'b0;
            d.cnt = 6'((EXT_MOVE_BASE_MC + int'(stretch_i)) * CLK_PER_MACHINE_CYCLE - 1);
            d.state = DMD_EXT_ADDR;
          end
        end
      end
      DMD_ONCHIP: begin
        // the SRAM read started in the request cycle; its data waits here
        d.cnt = q.cnt - 6'h01;
        if (q.cnt == 6'h00) begin
          if (!q.xwr) begin
            d.xdata = xram_rdata;
          end
          d.xdone = 1'b1;
          d.state = DMD_IDLE;
        end
      end
      DMD_EXT_ADDR: begin
        d.ale = 1'b0;
        d.cnt = q.cnt - 6'h01;
        if (q.xwr) begin
          d.ad_out = q.xwdata;
          d.wr_n = 1'b0;
        end else begin
          // release the low port on the same edge that starts the read strobe so the memory can drive it
          d.ad_oe_n = 1'b1;
          d.rd_n = 1'b0;
        end
        d.state = DMD_EXT_STROBE;
      end
      DMD_EXT_STROBE: begin
        d.cnt = q.cnt - 6'h01;
        if (q.cnt == 6'(STROBE_END_LEFT)) begin
          // synchroniser lag means this is pin data from inside the strobe
          if (!q.xwr) begin
            d.xdata = q.sync2;
          end
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          d.state = DMD_EXT_END;
        end
      end
      DMD_EXT_END: begin
        // bus stays released for the last cycles before done
        d.ad_oe_n = 1'b1;
        d.cnt = q.cnt - 6'h01;
        if (q.cnt == 6'h00) begin
          d.xdone = 1'b1;
          d.state = DMD_IDLE;
        end
      end
      default: begin
        d.state = DMD_IDLE;
      end
    endcase

    // busy and the active pointer are registered so no output is a decode
    d.busy = (d.state != DMD_IDLE);
    if (d.pointer_select) begin
      d.aptr = d.dp1;
    end else begin
      d.aptr = d.dp0;
    end
  end

  // the SRAM array itself is cleared inside its own module
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q.stack_pointer <= STACK_POINTER_RST;
      q.dp0 <= DATA_POINTER_RST;
      q.dp1 <= DATA_POINTER_RST;
      q.pointer_select <= POINTER_SELECT_RST;
      q.onchip_xram_enable <= ONCHIP_XRAM_ENABLE_RST;
      q.rdata <= UNIMPL_READ;
      q.sfr_sel <= 1'b0;
      q.scratch_sel <= 1'b0;
      q.bit_ok <= 1'b0;
      q.code_addr <= 16'h0000;
      q.state <= DMD_IDLE;
      q.cnt <= 6'h00;
      q.xwr <= 1'b0;
      q.xdata <= 8'h00;
      q.xdone <= 1'b0;
      q.ale <= 1'b0;
      q.rd_n <= 1'b1;
      q.wr_n <= 1'b1;
      q.addr_hi <= 8'h00;
      q.ad_out <= 8'h00;
      q.ad_oe_n <= 1'b1;
      q.sync1 <= 8'h00;
      q.sync2 <= 8'h00;
      q.busy <= 1'b0;
      q.aptr <= DATA_POINTER_RST;
      q.xwdata <= 8'h00;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata_o = q.rdata;
  assign sfr_sel_o = q.sfr_sel;
  assign scratch_sel_o = q.scratch_sel;
  assign bit_ok_o = q.bit_ok;
  assign stack_pointer_o = q.stack_pointer;
  assign code_addr_o = q.code_addr;
  assign xmove_rdata_o = q.xdata;
  assign xmove_done_o = q.xdone;
  // every output is a flop field; nothing combinational leaves the block
  assign xmove_busy_o = q.busy;
  assign active_data_pointer_o = q.aptr;
  assign ext_ale_o = q.ale;
  assign ext_rd_n_o = q.rd_n;
  assign ext_wr_n_o = q.wr_n;
  assign ext_addr_hi_o = q.addr_hi;
  assign ext_ad_o = q.ad_out;
  assign ext_ad_oe_n_o = q.ad_oe_n;
endmodule

/* File: dmd_ext_mem.sv */
// external data memory model on the multiplexed port bus
`timescale 1ns/100ps
module dmd_ext_mem (
  // bus from the device
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] addr_hi_i,
  input wire logic [7:0] ad_i,
  input wire logic ad_oe_n_i,
  // data driven back
  output logic [7:0] ad_o
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_q = 16'h0000;
  logic [7:0] last_q = 8'h00;
  always @(posedge clk_i) begin
    if (ale_i) addr_q <= {addr_hi_i, ad_i};
    if (!wr_n_i && !ad_oe_n_i) mem[addr_q] <= ad_i;
    if (!rd_n_i) last_q <= mem[addr_q];
  end
  // a released bus shows the inverse of the last value so stale data never passes
  assign ad_o = !rd_n_i ? mem[addr_q] : ~last_q;
endmodule

/* File: dmd_pkg.sv */
// shared constants and types for the data memory space decoder
package dmd_pkg;
  // special function register addresses owned by this block
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] SFR_STACK_POINTER = 8'h81;
  localparam logic [7:0] SFR_DATA_POINTER0_LOW = 8'h82;
  localparam logic [7:0] SFR_DATA_POINTER0_HIGH = 8'h83;
  localparam logic [7:0] SFR_DATA_POINTER1_LOW = 8'h84;
  localparam logic [7:0] SFR_DATA_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] SFR_POINTER_SELECT = 8'h86;
  localparam logic [7:0] SFR_MEMORY_MODE_CONTROL = 8'hC4;

  // field positions
  localparam int ONCHIP_XRAM_ENABLE_BIT = 0;
  localparam int POINTER_SELECT_BIT = 0;

  // reset values
  localparam logic [7:0] STACK_POINTER_RST = 8'h07;
  localparam logic [15:0] DATA_POINTER_RST = 16'h0000;
  localparam logic POINTER_SELECT_RST = 1'b0;
  localparam logic ONCHIP_XRAM_ENABLE_RST = 1'b0;

  // read values of unused positions
  localparam logic [7:0] UNIMPL_READ = 8'hFF;
  localparam logic [6:0] POINTER_SELECT_RSVD = 7'h00;
  localparam logic [6:0] MEMORY_MODE_UNIMPL = 7'h7F;

  // address map of the on-chip data SRAM
  localparam int XRAM_ADDR_W = 10;
  localparam logic [15:0] XRAM_FIRST = 16'h0000;
  localparam logic [15:0] XRAM_LAST = 16'h03FF;

  // instruction decode
  localparam logic [7:0] OPC_POINTER_DECREMENT = 8'hA5;

  // timing counts, in clocks and machine cycles
  localparam int CLK_PER_MACHINE_CYCLE = 4;
  localparam int ONCHIP_MOVE_MC = 2;
  localparam int EXT_MOVE_BASE_MC = 2;
  localparam int ONCHIP_MOVE_CLKS = ONCHIP_MOVE_MC * CLK_PER_MACHINE_CYCLE;
  localparam int STROBE_END_LEFT = 2;

  typedef enum logic [2:0] {
    DMD_IDLE = 3'b000,
    DMD_ONCHIP = 3'b001,
    DMD_EXT_ADDR = 3'b010,
    DMD_EXT_STROBE = 3'b011,
    DMD_EXT_END = 3'b100
  } dmd_state_t;
endpackage

/* File: dmd_props.sv */
// assertion checker for the data memory space decoder
`timescale 1ns/100ps
module dmd_props
  import dmd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // core side
  input wire logic iram_req_i,
  input wire logic iram_wr_i,
  input wire logic iram_indirect_i,
  input wire logic [7:0] iram_addr_i,
  input wire logic opcode_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic stack_push_i,
  input wire logic stack_pop_i,
  input wire logic xmove_req_i,
  input wire logic [2:0] stretch_i,
  // design outputs
  input wire logic sfr_sel_o,
  input wire logic scratch_sel_o,
  input wire logic bit_ok_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic xmove_done_o,
  input wire logic xmove_busy_o,
  input wire logic [15:0] active_data_pointer_o,
  input wire logic ext_ale_o,
  input wire logic ext_rd_n_o,
  input wire logic ext_ad_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire dir_sfr = iram_req_i && !iram_indirect_i && iram_addr_i[7];
  wire reg_wr = iram_req_i && iram_wr_i;
  wire take = xmove_req_i && !xmove_busy_o;
  AST_SFR_DIRECT: assert property (dir_sfr |=> sfr_sel_o && !scratch_sel_o)
    else $error("direct register access not decoded");
  AST_SCRATCH: assert property (iram_req_i && !dir_sfr |=> scratch_sel_o && !sfr_sel_o)
    else $error("scratchpad access not decoded");
  AST_BIT_OK: assert property (dir_sfr |=> bit_ok_o == ($past(iram_addr_i[2:0]) == 3'h0))
    else $error("bit access flag wrong");
  AST_DEC: assert property (opcode_valid_i && opcode_i == OPC_POINTER_DECREMENT && !reg_wr
    |=> active_data_pointer_o == $past(active_data_pointer_o) - 16'h0001)
    else $error("pointer not decremented by one");
  AST_SP_PUSH: assert property (stack_push_i && !stack_pop_i && !reg_wr
    |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01)
    else $error("stack pointer push wrong");
  AST_SP_POP: assert property (stack_pop_i && !stack_push_i && !reg_wr
    |=> stack_pointer_o == $past(stack_pointer_o) - 8'h01)
    else $error("stack pointer pop wrong");
  AST_BUSY: assert property (take |=> xmove_busy_o)
    else $error("move not marked busy");
  AST_ONCHIP_LEN: assert property (take ##1 !ext_ale_o |-> ##8 xmove_done_o)
    else $error("on-chip move length wrong");
  AST_EXT_LEN: assert property (take && stretch_i == 3'h0 ##1 ext_ale_o |-> ##8 xmove_done_o)
    else $error("external move length wrong");
  AST_ALE_DRIVE: assert property (ext_ale_o |-> !ext_ad_oe_n_o)
    else $error("address not driven with latch pulse");
  AST_RD_RELEASE: assert property (!ext_rd_n_o |-> ext_ad_oe_n_o)
    else $error("bus driven during read strobe");
  cover property (take ##1 !ext_ale_o);
  cover property (take ##1 ext_ale_o);
  cover property (opcode_valid_i && opcode_i == OPC_POINTER_DECREMENT);
endmodule

bind dmd_data_memory dmd_props dmd_props_inst (.*);

/* File: dmd_space_decode.sv */
// combinational decode of scratchpad, register and external data spaces
`timescale 1ns/100ps
module dmd_space_decode (
  // internal data access
  input wire logic [7:0] iram_addr_i,
  input wire logic iram_indirect_i,
  // external data move address
  input wire logic [15:0] xmove_addr_i,
  input wire logic onchip_en_i,
  // decode results
  output logic sfr_sel_o,
  output logic scratch_sel_o,
  output logic bit_ok_o,
  output logic xram_hit_o
);
  import dmd_pkg::*;

  always_comb begin
    // upper half reached indirectly is scratchpad, directly is registers
    sfr_sel_o = (iram_addr_i >= SFR_BASE) && !iram_indirect_i;
    scratch_sel_o = !sfr_sel_o;
    // only registers at x0h or x8h take single bit access
    bit_ok_o = sfr_sel_o && (iram_addr_i[2:0] == 3'h0);
    // upper six address bits zero means inside 0000H..03FFH
    xram_hit_o = onchip_en_i && (xmove_addr_i[15:XRAM_ADDR_W] == 6'h00);
  end
endmodule

/* File: dmd_xram.sv */
// 1 KB on-chip data SRAM held in flip-flops, registered read
`timescale 1ns/100ps
module dmd_xram #(
  parameter int AW = dmd_pkg::XRAM_ADDR_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // access port
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  typedef struct packed {
    logic [(1<<AW)-1:0][7:0] mem;
    logic [7:0] rdata;
  } dmd_xram_st_t;

  dmd_xram_st_t q;
  dmd_xram_st_t d;

  always_comb begin
    d = q;
    if (en_i && we_i) begin
      d.mem[addr_i] = wdata_i;
    end
    if (en_i && !we_i) begin
      d.rdata = q.mem[addr_i];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
endmodule
